/* rtl/fault_alarm_params.svh */
`ifndef FAULT_ALARM_PARAMS_SVH
`define FAULT_ALARM_PARAMS_SVH

// ------------------------------------------------------------
// entry layout of the recorded error vector
// ------------------------------------------------------------
`define FAR_N_CRIT 15
`define FAR_N_WARN 11
`define FAR_N_MISC 5
`define FAR_N_ENTRIES 31
`define FAR_WARN_BASE 15
`define FAR_MISC_BASE 26
`define FAR_WARN_DIG_IN 0

// ------------------------------------------------------------
// critical codes, three bcd digits, hundreds digit is the board
// ------------------------------------------------------------
`define FAR_C_PROM_ACQ 12'h100
`define FAR_C_PROM_SIG 12'h207
`define FAR_C_PROM_SYS 12'h515
`define FAR_C_LRAM_ACQ 12'h101
`define FAR_C_LRAM_SIG 12'h208
`define FAR_C_LRAM_SYS 12'h516
`define FAR_C_INT_SIG 12'h210
`define FAR_C_INT_SYS 12'h519
`define FAR_C_TIMER_ACQ 12'h106
`define FAR_C_ADC_CTRL 12'h311
`define FAR_C_NVM_ANA 12'h312
`define FAR_C_NVM_MAG 12'h414
`define FAR_C_REFERENCE 12'h313
`define FAR_C_MODEL 12'h422
`define FAR_C_DIG_OUT 12'h621

// ------------------------------------------------------------
// warning codes
// ------------------------------------------------------------
`define FAR_W_DIG_IN 12'h235
`define FAR_W_TIMER 12'h537
`define FAR_W_CAPTURE 12'h538
`define FAR_W_RTC 12'h539
`define FAR_W_PRINTER 12'h640
`define FAR_W_DISPLAY 12'h641
`define FAR_W_REAR_PORT 12'h645
`define FAR_W_FRONT_PORT 12'h646
`define FAR_W_SERIAL_MEM 12'h844
`define FAR_W_TIME_STROBE 12'h643
`define FAR_W_LOGIN 12'h742
`define FAR_NO_CODE 12'h000

// ------------------------------------------------------------
// restart defaults after long power loss
// ------------------------------------------------------------
`define FAR_LONG_LOSS_HOURS 24
`define FAR_TIME_DEFAULT 24'h000000
`define FAR_DATE_DEFAULT 24'h010190

// ------------------------------------------------------------
// information menu
// ------------------------------------------------------------
`define FAR_MENU_ITEMS 8
`define FAR_MENU_STATUS 0

`endif

/* rtl/fault_alarm_pkg.sv */
`include "fault_alarm_params.svh"

package fault_alarm_pkg;

    typedef enum logic [1:0] {MSG_NONE, MSG_FAIL, MSG_WARN} msg_kind_t;
    typedef enum logic [1:0] {CAT_OK, CAT_FAIL, CAT_WARN, CAT_MISC} category_t;

    typedef struct packed {
        msg_kind_t kind;
        logic [11:0] code;
    } held_msg_t;

    typedef struct packed {
        logic valid;
        category_t cat;
        logic detail;
        logic [4:0] entry;
        logic [11:0] code;
    } status_view_t;

    typedef struct packed {
        logic info_menu_key;
        logic up_key;
        logic down_key;
        logic confirm_key;
        logic print_key;
        logic other_key;
    } keys_t;

    typedef struct packed {
        logic protection_disabled;
        logic outputs_inhibited;
        logic relay_test;
        logic dout_test;
        logic channel_test;
    } misc_t;

    typedef struct packed {
        logic minor;
        logic major;
        logic led;
    } sys_status_t;

    typedef struct packed {
        logic valid;
        logic [23:0] time_bcd;
        logic [23:0] date_bcd;
    } rtc_preset_t;

    // code of one recorded entry
    function automatic logic [11:0] entry_code(input logic [4:0] idx);
        case (idx)
            5'h00: return `FAR_C_PROM_ACQ;
            5'h01: return `FAR_C_PROM_SIG;
            5'h02: return `FAR_C_PROM_SYS;
            5'h03: return `FAR_C_LRAM_ACQ;
            5'h04: return `FAR_C_LRAM_SIG;
            5'h05: return `FAR_C_LRAM_SYS;
            5'h06: return `FAR_C_INT_SIG;
            5'h07: return `FAR_C_INT_SYS;
            5'h08: return `FAR_C_TIMER_ACQ;
            5'h09: return `FAR_C_ADC_CTRL;
            5'h0a: return `FAR_C_NVM_ANA;
            5'h0b: return `FAR_C_NVM_MAG;
            5'h0c: return `FAR_C_REFERENCE;
            5'h0d: return `FAR_C_MODEL;
            5'h0e: return `FAR_C_DIG_OUT;
            5'h0f: return `FAR_W_DIG_IN;
            5'h10: return `FAR_W_TIMER;
            5'h11: return `FAR_W_CAPTURE;
            5'h12: return `FAR_W_RTC;
            5'h13: return `FAR_W_PRINTER;
            5'h14: return `FAR_W_DISPLAY;
            5'h15: return `FAR_W_REAR_PORT;
            5'h16: return `FAR_W_FRONT_PORT;
            5'h17: return `FAR_W_SERIAL_MEM;
            5'h18: return `FAR_W_TIME_STROBE;
            5'h19: return `FAR_W_LOGIN;
            default: return `FAR_NO_CODE;
        endcase
    endfunction : entry_code

endpackage : fault_alarm_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = pin;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign synced = sync_q;

endmodule : pin_sync

`default_nettype wire

/* rtl/fault_code_encoder.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fault_alarm_params.svh"

module fault_code_encoder #(
    parameter int N_CRIT = `FAR_N_CRIT,
    parameter int N_WARN = `FAR_N_WARN
) (
    input wire logic [N_CRIT-1:0] crit,
    input wire logic [N_WARN-1:0] warn,
    output logic [11:0] crit_code,
    output logic [11:0] warn_code
);

    // ------------------------------------------------------------
    // lowest set entry wins
    // ------------------------------------------------------------
    always_comb
    begin
        crit_code = `FAR_NO_CODE;
        warn_code = `FAR_NO_CODE;
        for (int i = N_CRIT - 1; i >= 0; i--)
        begin
            if (crit[i])
            begin
                crit_code = fault_alarm_pkg::entry_code(5'(i));
            end
        end
        for (int j = N_WARN - 1; j >= 0; j--)
        begin
            if (warn[j])
            begin
                warn_code = fault_alarm_pkg::entry_code(5'(j + `FAR_WARN_BASE));
            end
        end
    end

endmodule : fault_code_encoder

`default_nettype wire

/* rtl/fault_alarm_reporter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fault_alarm_params.svh"

module fault_alarm_reporter #(
    parameter int MENU_ITEMS = `FAR_MENU_ITEMS,
    parameter int MENU_STATUS = `FAR_MENU_STATUS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [`FAR_N_CRIT-1:0] crit_fail_in,
    input wire logic [`FAR_N_WARN-1:0] warn_in,
    input wire fault_alarm_pkg::misc_t misc_in,
    input wire fault_alarm_pkg::sys_status_t sys_in,
    input wire fault_alarm_pkg::keys_t keys_in,
    input wire logic restart_done,
    input wire logic selftest_ok,
    input wire logic long_power_loss,
    input wire logic modem_req,
    input wire logic modem_next,
    output logic major_alarm_contact,
    output logic minor_alarm_contact,
    output logic lamp_red,
    output logic pilot_protection_off,
    output fault_alarm_pkg::held_msg_t held_msg,
    output fault_alarm_pkg::status_view_t panel_view,
    output fault_alarm_pkg::status_view_t modem_view,
    output logic print_req,
    output logic records_clear,
    output fault_alarm_pkg::rtc_preset_t rtc_preset
);

    localparam int PIN_W = `FAR_N_CRIT + `FAR_N_WARN + 5 + 3 + 6;
    localparam int MW = $clog2(MENU_ITEMS);

    typedef enum logic [1:0] {Q_IDLE, Q_MENU, Q_SUMMARY, Q_DETAIL} query_state_t;

    // ------------------------------------------------------------
    // next recorded entry after cur, wrapping
    // ------------------------------------------------------------
    function automatic logic [4:0] next_entry(input logic [30:0] v, input logic [4:0] cur);
        logic [4:0] r;
        logic found;
        int k;
        r = cur;
        found = 1'b0;
        for (int i = 1; i <= `FAR_N_ENTRIES; i++)
        begin
            k = (int'(cur) + i) % `FAR_N_ENTRIES;
            if (!found && v[k])
            begin
                r = 5'(k);
                found = 1'b1;
            end
        end
        return r;
    endfunction : next_entry

    // ------------------------------------------------------------
    // overall category, fail before warn before misc
    // ------------------------------------------------------------
    function automatic fault_alarm_pkg::category_t category_of(input logic fail,
                                                               input logic warn,
                                                               input logic misc);
        if (fail)
        begin
            return fault_alarm_pkg::CAT_FAIL;
        end
        if (warn)
        begin
            return fault_alarm_pkg::CAT_WARN;
        end
        if (misc)
        begin
            return fault_alarm_pkg::CAT_MISC;
        end
        return fault_alarm_pkg::CAT_OK;
    endfunction : category_of

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pins_s;
    logic [`FAR_N_CRIT-1:0] crit_s;
    logic [`FAR_N_WARN-1:0] warn_s;
    fault_alarm_pkg::misc_t misc_s;
    fault_alarm_pkg::sys_status_t sys_s;
    fault_alarm_pkg::keys_t keys_s;

    pin_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin({crit_fail_in, warn_in, misc_in, sys_in, keys_in}),
        .synced(pins_s)
    );

    assign {crit_s, warn_s, misc_s, sys_s, keys_s} = pins_s;

    logic [11:0] crit_code;
    logic [11:0] warn_code;

    fault_code_encoder u_enc (
        .crit(crit_s),
        .warn(warn_s),
        .crit_code(crit_code),
        .warn_code(warn_code)
    );

    // ------------------------------------------------------------
    // alarm state, held message, records
    // ------------------------------------------------------------
    logic crit_lat_q, crit_lat_d;
    logic [`FAR_N_CRIT-1:0] crit_prev_q, crit_prev_d;
    logic [`FAR_N_WARN-1:0] warn_prev_q, warn_prev_d;
    logic [30:0] rec_q, rec_d;
    fault_alarm_pkg::keys_t keys_prev_q, keys_prev_d;
    fault_alarm_pkg::held_msg_t msg_q, msg_d;
    logic major_q, major_d;
    logic minor_q, minor_d;
    logic red_q, red_d;
    logic pilot_q, pilot_d;
    logic clr_q, clr_d;
    fault_alarm_pkg::rtc_preset_t rtc_q, rtc_d;
    fault_alarm_pkg::keys_t ke;
    logic clean_restart;
    logic misc_lamp;
    logic warn_any;

    always_comb
    begin
        ke = keys_s & ~keys_prev_q;
        clean_restart = restart_done && selftest_ok;
        warn_any = |warn_s;
        misc_lamp = misc_s.protection_disabled | misc_s.outputs_inhibited
                  | misc_s.relay_test | misc_s.dout_test;
        crit_prev_d = crit_s;
        warn_prev_d = warn_s;
        keys_prev_d = keys_s;
        crit_lat_d = crit_lat_q;
        if (clean_restart)
        begin
            crit_lat_d = 1'b0;
        end
        if (|crit_s)
        begin
            crit_lat_d = 1'b1;
        end
        rec_d = rec_q;
        if (restart_done && long_power_loss)
        begin
            rec_d = '0;
        end
        rec_d = rec_d | {misc_s, warn_s, crit_s};
        msg_d = msg_q;
        if (clean_restart || (|ke))
        begin
            msg_d.kind = fault_alarm_pkg::MSG_NONE;
            msg_d.code = `FAR_NO_CODE;
        end
        if ((|(warn_s & ~warn_prev_q)) && (msg_d.kind != fault_alarm_pkg::MSG_FAIL))
        begin
            msg_d.kind = fault_alarm_pkg::MSG_WARN;
            msg_d.code = warn_code;
        end
        if (|(crit_s & ~crit_prev_q))
        begin
            msg_d.kind = fault_alarm_pkg::MSG_FAIL;
            msg_d.code = crit_code;
        end
        // system status touches contacts, lamp and view category only
        major_d = crit_lat_d | sys_s.major;
        minor_d = warn_any | sys_s.minor;
        red_d = crit_lat_d | sys_s.led | misc_lamp;
        pilot_d = warn_s[`FAR_WARN_DIG_IN];
        clr_d = restart_done && long_power_loss;
        rtc_d.valid = clr_d;
        rtc_d.time_bcd = `FAR_TIME_DEFAULT;
        rtc_d.date_bcd = `FAR_DATE_DEFAULT;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            crit_lat_q <= 1'b1;
            crit_prev_q <= '0;
            warn_prev_q <= '0;
            keys_prev_q <= '0;
            rec_q <= '0;
            msg_q <= '0;
            major_q <= 1'b1;
            minor_q <= 1'b0;
            red_q <= 1'b1;
            pilot_q <= 1'b0;
            clr_q <= 1'b0;
            rtc_q <= '0;
        end
        else
        begin
            crit_lat_q <= crit_lat_d;
            crit_prev_q <= crit_prev_d;
            warn_prev_q <= warn_prev_d;
            keys_prev_q <= keys_prev_d;
            rec_q <= rec_d;
            msg_q <= msg_d;
            major_q <= major_d;
            minor_q <= minor_d;
            red_q <= red_d;
            pilot_q <= pilot_d;
            clr_q <= clr_d;
            rtc_q <= rtc_d;
        end
    end

    // ------------------------------------------------------------
    // status query, panel and modem
    // ------------------------------------------------------------
    query_state_t qs_q, qs_d;
    logic [MW-1:0] menu_q, menu_d;
    fault_alarm_pkg::status_view_t pv_q, pv_d;
    fault_alarm_pkg::status_view_t mv_q, mv_d;
    logic prt_q, prt_d;
    fault_alarm_pkg::category_t cat_now;
    logic at_status;

    always_comb
    begin
        cat_now = category_of(crit_lat_q | sys_s.major, (|warn_s) | sys_s.minor,
                              (|rec_q[30:`FAR_MISC_BASE]) | sys_s.led);
        at_status = (menu_q == MW'(MENU_STATUS));
        qs_d = qs_q;
        menu_d = menu_q;
        pv_d = pv_q;
        prt_d = 1'b0;
        case (qs_q)
            Q_IDLE:
            begin
                if (ke.info_menu_key)
                begin
                    qs_d = Q_MENU;
                    menu_d = '0;
                end
            end
            Q_MENU:
            begin
                if (ke.up_key)
                begin
                    menu_d = (menu_q == MW'(MENU_ITEMS - 1)) ? '0 : menu_q + 1'b1;
                end
                else if (ke.down_key)
                begin
                    menu_d = (menu_q == '0) ? MW'(MENU_ITEMS - 1) : menu_q - 1'b1;
                end
                else if (ke.print_key && at_status)
                begin
                    prt_d = 1'b1;
                end
                else if (ke.confirm_key && at_status)
                begin
                    qs_d = Q_SUMMARY;
                    pv_d.entry = 5'(`FAR_N_ENTRIES - 1);
                end
            end
            Q_SUMMARY, Q_DETAIL:
            begin
                if (ke.up_key && (|rec_q))
                begin
                    qs_d = Q_DETAIL;
                    pv_d.entry = next_entry(rec_q, pv_q.entry);
                end
                else if (ke.info_menu_key)
                begin
                    qs_d = Q_MENU;
                end
                else if (ke.confirm_key)
                begin
                    qs_d = Q_IDLE;
                end
            end
            default:
            begin
                qs_d = Q_IDLE;
            end
        endcase
        pv_d.valid = (qs_d == Q_SUMMARY) || (qs_d == Q_DETAIL);
        pv_d.detail = (qs_d == Q_DETAIL);
        pv_d.cat = cat_now;
        pv_d.code = pv_d.detail ? fault_alarm_pkg::entry_code(pv_d.entry) : `FAR_NO_CODE;
        // same content for the remote line
        mv_d = mv_q;
        if (modem_req)
        begin
            mv_d.valid = 1'b1;
            mv_d.detail = 1'b0;
            mv_d.entry = 5'(`FAR_N_ENTRIES - 1);
        end
        else if (modem_next && mv_q.valid && (|rec_q))
        begin
            mv_d.detail = 1'b1;
            mv_d.entry = next_entry(rec_q, mv_q.entry);
        end
        mv_d.cat = cat_now;
        mv_d.code = mv_d.detail ? fault_alarm_pkg::entry_code(mv_d.entry) : `FAR_NO_CODE;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            qs_q <= Q_IDLE;
            menu_q <= '0;
            pv_q <= '0;
            mv_q <= '0;
            prt_q <= 1'b0;
        end
        else
        begin
            qs_q <= qs_d;
            menu_q <= menu_d;
            pv_q <= pv_d;
            mv_q <= mv_d;
            prt_q <= prt_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign major_alarm_contact = major_q;
    assign minor_alarm_contact = minor_q;
    assign lamp_red = red_q;
    assign pilot_protection_off = pilot_q;
    assign held_msg = msg_q;
    assign panel_view = pv_q;
    assign modem_view = mv_q;
    assign print_req = prt_q;
    assign records_clear = clr_q;
    assign rtc_preset = rtc_q;

endmodule : fault_alarm_reporter

`default_nettype wire

/* tb/alarm_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// alarm and message checker
// ------------------------------------------------------------
module alarm_monitor (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [14:0] crit_fail_in,
    input wire logic [10:0] warn_in,
    input wire fault_alarm_pkg::misc_t misc_in,
    input wire fault_alarm_pkg::sys_status_t sys_in,
    input wire logic restart_done,
    input wire logic selftest_ok,
    input wire logic long_power_loss,
    input wire logic modem_req,
    input wire logic major_alarm_contact,
    input wire logic minor_alarm_contact,
    input wire logic lamp_red,
    input wire logic pilot_protection_off,
    input wire fault_alarm_pkg::held_msg_t held_msg,
    input wire fault_alarm_pkg::status_view_t modem_view,
    input wire logic print_req,
    input wire logic records_clear,
    input wire fault_alarm_pkg::rtc_preset_t rtc_preset
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    AST_MAJOR: assert property ((|crit_fail_in)[*3]
        |=> major_alarm_contact && lamp_red)
        else $error("major alarm or red lamp missing");
    AST_MINOR: assert property ((|warn_in)[*3] |=> minor_alarm_contact)
        else $error("minor alarm missing");
    AST_PILOT_ON: assert property (warn_in[0][*3] |=> pilot_protection_off)
        else $error("pilot protection still on");
    AST_PILOT_OFF: assert property ((!warn_in[0])[*3] |=> !pilot_protection_off)
        else $error("pilot protection off without cause");
    AST_MISC_RED: assert property (misc_in.protection_disabled[*3] |=> lamp_red)
        else $error("lamp not red with protection off");
    AST_BOARD: assert property (held_msg.kind == fault_alarm_pkg::MSG_FAIL
        |-> held_msg.code[11:8] inside {[4'h1:4'h6]})
        else $error("fail code names no board");
    AST_CLEAR: assert property ((crit_fail_in == 15'h0000 && warn_in == 11'h000)[*3]
        ##0 (restart_done && selftest_ok) |=> held_msg.kind == fault_alarm_pkg::MSG_NONE)
        else $error("message kept after clean restart");
    AST_GREEN: assert property ((crit_fail_in == 15'h0000 && misc_in == 5'h00
        && sys_in == 3'h0)[*3] ##0 (restart_done && selftest_ok) |-> ##[1:2] !lamp_red)
        else $error("lamp not green after clean restart");
    AST_PRESET: assert property (restart_done && long_power_loss |=> records_clear
        && rtc_preset.valid && rtc_preset.time_bcd == 24'h000000
        && rtc_preset.date_bcd == 24'h010190)
        else $error("no clock preset after long power loss");
    AST_MODEM: assert property (modem_req |=> modem_view.valid && !modem_view.detail)
        else $error("remote query not answered");
    AST_PRINT: assert property (print_req |=> !print_req)
        else $error("print request longer than one cycle");
endmodule : alarm_monitor

bind fault_alarm_reporter alarm_monitor mon (.core_clk, .resetn, .crit_fail_in, .warn_in,
    .misc_in, .sys_in, .restart_done, .selftest_ok, .long_power_loss, .modem_req,
    .major_alarm_contact, .minor_alarm_contact, .lamp_red, .pilot_protection_off,
    .held_msg, .modem_view, .print_req, .records_clear, .rtc_preset);
`default_nettype wire

/* tb/keypad_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// keypad: holds a pressed key four cycles
// ------------------------------------------------------------
module keypad_model (
    input wire logic core_clk,
    input wire fault_alarm_pkg::keys_t press,
    output var fault_alarm_pkg::keys_t keys
);
    int hold_cnt = 0;
    initial keys = '0;
    always @(negedge core_clk)
    begin
        if (press != '0)
        begin
            keys <= press;
            hold_cnt <= 4;
        end
        else if (hold_cnt > 1)
            hold_cnt <= hold_cnt - 1;
        else
            keys <= '0;
    end
endmodule : keypad_model
`default_nettype wire

/* tb/fault_alarm_reporter_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module fault_alarm_reporter_bench;
    logic core_clk, resetn, restart_done, selftest_ok, long_power_loss, modem_req, modem_next;
    logic [14:0] crit_fail_in;
    logic [10:0] warn_in;
    fault_alarm_pkg::misc_t misc_in;
    fault_alarm_pkg::sys_status_t sys_in;
    fault_alarm_pkg::keys_t keys_in, press;
    logic major_alarm_contact, minor_alarm_contact, lamp_red, pilot_protection_off;
    logic print_req, records_clear;
    fault_alarm_pkg::held_msg_t held_msg;
    fault_alarm_pkg::status_view_t panel_view, modem_view;
    fault_alarm_pkg::rtc_preset_t rtc_preset;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int prints = 0;
    logic [11:0] codes [26] = '{12'h100, 12'h207, 12'h515, 12'h101, 12'h208, 12'h516,
        12'h210, 12'h519, 12'h106, 12'h311, 12'h312, 12'h414, 12'h313, 12'h422, 12'h621,
        12'h235, 12'h537, 12'h538, 12'h539, 12'h640, 12'h641, 12'h645, 12'h646, 12'h844,
        12'h643, 12'h742};

    fault_alarm_reporter DUT (.core_clk, .resetn, .crit_fail_in, .warn_in, .misc_in,
        .sys_in, .keys_in, .restart_done, .selftest_ok, .long_power_loss, .modem_req,
        .modem_next, .major_alarm_contact, .minor_alarm_contact, .lamp_red,
        .pilot_protection_off, .held_msg, .panel_view, .modem_view, .print_req,
        .records_clear, .rtc_preset);
    keypad_model pad (.core_clk, .press, .keys(keys_in));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
    begin
        cyc++;
        prints += (print_req === 1'b1);
        if (cyc == 3000)
        begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n

    task automatic restart(input logic lpl);
        @(negedge core_clk);
        restart_done = 1'b1;
        selftest_ok = 1'b1;
        long_power_loss = lpl;
        @(negedge core_clk);
        restart_done = 1'b0;
        long_power_loss = 1'b0;
    endtask : restart

    task automatic key(input fault_alarm_pkg::keys_t k);
        press <= k;
        @(negedge core_clk);
        press <= '0;
        wait_n(8);
    endtask : key

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {resetn, restart_done, selftest_ok, long_power_loss, modem_req, modem_next} = '0;
        {crit_fail_in, warn_in, misc_in, sys_in, press} = '0;
        wait_n(6);
        `CHK("rst major", 1'b1, major_alarm_contact)
        `CHK("rst lamp", 1'b1, lamp_red)
        `CHK("rst minor", 1'b0, minor_alarm_contact)
        resetn = 1'b1;
        restart(1'b0);
        wait_n(3);
        `CHK("green", 1'b0, lamp_red)
        for (int i = 0; i < 26; i++)
        begin
            {warn_in, crit_fail_in} = 26'h1 << i;
            wait_n(4);
            `CHK("kind", (i < 15) ? 2'h1 : 2'h2, held_msg.kind)
            `CHK("code", codes[i], held_msg.code)
            `CHK("major", i < 15, major_alarm_contact)
            `CHK("minor", i >= 15, minor_alarm_contact)
            `CHK("lamp", i < 15, lamp_red)
            `CHK("pilot", i == 15, pilot_protection_off)
            {warn_in, crit_fail_in} = '0;
            wait_n(4);
            restart(1'b0);
            wait_n(3);
            `CHK("cleared", 2'h0, held_msg.kind)
        end
        // ------------------------------------------------------------
        // awkward cases
        // ------------------------------------------------------------
        warn_in = 11'h080;
        resetn = 1'b0;
        wait_n(3);
        resetn = 1'b1;
        wait_n(4);
        `CHK("warn again", 12'h646, held_msg.code)
        crit_fail_in = 15'h2000;
        wait_n(4);
        `CHK("fail wins", 12'h422, held_msg.code)
        `CHK("minor kept", 1'b1, minor_alarm_contact)
        key(6'h01);
        `CHK("key clear", 2'h0, held_msg.kind)
        `CHK("latched", 1'b1, major_alarm_contact)
        {warn_in, crit_fail_in} = '0;
        wait_n(4);
        restart(1'b0);
        for (int j = 0; j < 5; j++)
        begin
            misc_in = 5'h10 >> j;
            wait_n(4);
            `CHK("misc lamp", j != 4, lamp_red)
            misc_in = '0;
            wait_n(4);
        end
        sys_in = 3'h2;
        wait_n(4);
        `CHK("sys major", 1'b1, major_alarm_contact)
        `CHK("sys silent", 2'h0, held_msg.kind)
        sys_in = '0;
        wait_n(4);
        restart(1'b1);
        `CHK("records", 1'b1, records_clear)
        `CHK("preset", 49'h1_0000_0001_0190, rtc_preset)
        warn_in = 11'h010;
        wait_n(4);
        modem_req = 1'b1;
        @(negedge core_clk);
        modem_req = 1'b0;
        wait_n(2);
        `CHK("modem cat", 3'h6, {modem_view.valid, modem_view.cat})
        modem_next = 1'b1;
        @(negedge core_clk);
        modem_next = 1'b0;
        wait_n(2);
        `CHK("modem code", 13'h1640, {modem_view.detail, modem_view.code})
        key(6'h20);
        key(6'h08);
        key(6'h02);
        key(6'h10);
        key(6'h02);
        key(6'h04);
        `CHK("print", 1, prints)
        `CHK("panel cat", 3'h6, {panel_view.valid, panel_view.cat})
        key(6'h10);
        `CHK("panel code", 12'h640, panel_view.code)
        `CHK("panel det", 1'b1, panel_view.detail)
        close_out();
    end
endmodule : fault_alarm_reporter_bench
`default_nettype wire
